// [rmw_map.vh]
// constants, field layout and register map of the register read/write datapath
// Summary of operation
// RL1: function 101 writes byte operand register, after the operation, into addressed register.
// RL2: function 110 reads addressed register, operates, result goes to byte operand register.
// RL3: function 111 reads addressed register, operates, writes result back to it.
// RL4: operator 000 passes operand unchanged; plain move stores the immediate byte. Under function 101 the code stores the byte operand register instead.
// RL5: operator 001 shifts the source left one bit.
// RL6: operator 101 shifts the source right one bit.
// RL7: shifts rotate through carry: old carry enters, shifted-out bit becomes carry.
// RL8: operator 010 ORs source with second operand.
// RL9: operator 011 XORs source with second operand.
// RL10: operator 100 ANDs source with second operand.
// RL11: operator 110 adds second operand to source modulo 256.
// RL12: operator 111 adds second operand plus carry to source.
// RL13: bit 23 set selects byte operand register as second operand.
// RL14: 7-bit register-address field selects source, also destination in read-modify-write.
// RL15: 8-bit immediate field is the second operand for logic and arithmetic.
// RL16: shifts with register second operand need no defined result.
// RL17: sequencer never encodes a move between two different chip registers.
// RL18: results are computed at execution from current register contents.
// RL19: no-operation changes no register or bus state, only completes.
// RL20: top two bits 01 of the first word mark a read/write instruction.
// RL21: adds update carry from bit 7; logic and moves leave carry unchanged.
// RL22: sequencer fills reserved first-word byte and second word with zeros.
`ifndef RMW_MAP_VH
`define RMW_MAP_VH
`define RMW_TYPE_HI       31
`define RMW_TYPE_LO       30
`define RMW_TYPE_RW       2'h1
`define RMW_NOP_OPCODE    8'h80
`define RMW_FUNC_HI       29
`define RMW_FUNC_LO       27
`define RMW_FUNC_TO_REG   3'h5
`define RMW_FUNC_TO_BOR   3'h6
`define RMW_FUNC_RMW      3'h7
`define RMW_OPER_HI       26
`define RMW_OPER_LO       24
`define RMW_USE_BOR_BIT   23
`define RMW_ADDR_HI       22
`define RMW_ADDR_LO       16
`define RMW_IMM_HI        15
`define RMW_IMM_LO        8
`define RMW_OP_MOVE       3'h0
`define RMW_OP_SHL        3'h1
`define RMW_OP_OR         3'h2
`define RMW_OP_XOR        3'h3
`define RMW_OP_AND        3'h4
`define RMW_OP_SHR        3'h5
`define RMW_OP_ADD        3'h6
`define RMW_OP_ADDC       3'h7
`define RMW_AXI_CTRL      5'h00
`define RMW_AXI_WORD0     5'h04
`define RMW_AXI_WORD1     5'h08
`define RMW_AXI_STATUS    5'h0c
`define RMW_AXI_BOR       5'h10
`define RMW_CTRL_GO_BIT   0
`define RMW_ST_BUSY_BIT   0
`define RMW_ST_CARRY_BIT  1
`define RMW_ST_ILLEGAL_BIT 2
`define RMW_ST_DONE_BIT   3
`define RMW_RESP_OKAY     2'h0
`define RMW_RESP_SLVERR   2'h2
`endif

// [rmw_alu.v]
// register read/write and no-operation execution datapath with an axi4-lite control port
`timescale 1ns/1ps
`include "rmw_map.vh"
module rmw_alu (
    input  wire        clock,
    input  wire        resetn,
    input  wire [4:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [4:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg  [6:0]  chip_reg_addr,
    output reg         chip_reg_rd,
    input  wire [7:0]  chip_reg_rdata,
    output reg         chip_reg_wr,
    output reg  [7:0]  chip_reg_wdata,
    output reg  [7:0]  byte_operand_reg,
    output reg         carry,
    output reg         done
);

    localparam ST_IDLE  = 2'h0;
    localparam ST_READ  = 2'h1;
    localparam ST_WRITE = 2'h2;

    reg [31:0] instr_word0;
    reg [31:0] instr_word1;
    reg [1:0]  state;
    reg        illegal;
    reg        busy;
    reg        aw_held;
    reg        w_held;
    reg [4:0]  aw_addr;
    reg [31:0] w_data;
    reg [3:0]  w_strb;
    reg        go;
    reg [7:0]  src_byte;

    // strobe-merged write of one register word
    function [31:0] merge;
        input [31:0] old;
        input [31:0] new_val;
        input [3:0]  strb;
        integer      i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = new_val[i*8 +: 8];
                end
            end
        end
    endfunction

    wire [1:0] f_type = instr_word0[`RMW_TYPE_HI:`RMW_TYPE_LO];
    wire [2:0] f_func = instr_word0[`RMW_FUNC_HI:`RMW_FUNC_LO];
    wire [2:0] f_oper = instr_word0[`RMW_OPER_HI:`RMW_OPER_LO];
    wire       f_use  = instr_word0[`RMW_USE_BOR_BIT];
    wire [6:0] f_addr = instr_word0[`RMW_ADDR_HI:`RMW_ADDR_LO]; // RL14
    wire [7:0] f_imm  = instr_word0[`RMW_IMM_HI:`RMW_IMM_LO];   // RL15
    wire       is_rw  = (f_type == `RMW_TYPE_RW); // RL20
    wire       is_nop = (instr_word0[31:24] == `RMW_NOP_OPCODE);
    wire       func_ok = (f_func == `RMW_FUNC_TO_REG) || (f_func == `RMW_FUNC_TO_BOR) ||
                         (f_func == `RMW_FUNC_RMW);

    ////////////////////////////////////////////////////////////////////////////
    // alu: second operand and result, computed from live values at execution
    reg [7:0] operand_b;
    reg [7:0] alu_out;
    reg       alu_carry;
    reg [8:0] sum;
    always @* begin
        operand_b = f_use ? byte_operand_reg : f_imm; // RL13
        alu_out   = src_byte; // RL4 RL18
        alu_carry = carry;    // RL21
        sum       = 9'h000;
        case (f_oper)
            `RMW_OP_MOVE: begin
                // plain move with immediate in functions 110 and 111: immediate is the stored value
                if (f_func != `RMW_FUNC_TO_REG && !f_use) begin
                    alu_out = f_imm; // RL4
                end
            end
            `RMW_OP_SHL: begin
                // with register operand the shift is still done; result is undefined by spec
                alu_out   = {src_byte[6:0], carry}; // RL5 RL7 RL16
                alu_carry = src_byte[7];            // RL7
            end
            `RMW_OP_SHR: begin
                alu_out   = {carry, src_byte[7:1]}; // RL6 RL7 RL16
                alu_carry = src_byte[0];            // RL7
            end
            `RMW_OP_OR:  alu_out = src_byte | operand_b; // RL8
            `RMW_OP_XOR: alu_out = src_byte ^ operand_b; // RL9
            `RMW_OP_AND: alu_out = src_byte & operand_b; // RL10
            `RMW_OP_ADD: begin
                sum       = {1'b0, src_byte} + {1'b0, operand_b}; // RL11
                alu_out   = sum[7:0];
                alu_carry = sum[8]; // RL21
            end
            `RMW_OP_ADDC: begin
                sum       = {1'b0, src_byte} + {1'b0, operand_b} + {8'h00, carry}; // RL12
                alu_out   = sum[7:0];
                alu_carry = sum[8]; // RL21
            end
            default: alu_out = src_byte;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // execution sequencer
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state            <= ST_IDLE;
            busy             <= 1'b0;
            illegal          <= 1'b0;
            done             <= 1'b0;
            carry            <= 1'b0;
            byte_operand_reg <= 8'h00;
            src_byte         <= 8'h00;
            chip_reg_addr    <= 7'h00;
            chip_reg_rd      <= 1'b0;
            chip_reg_wr      <= 1'b0;
            chip_reg_wdata   <= 8'h00;
        end else begin
            chip_reg_rd <= 1'b0;
            chip_reg_wr <= 1'b0;
            done        <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (go) begin
                        busy    <= 1'b1;
                        illegal <= 1'b0;
                        if (is_nop) begin
                            busy <= 1'b0; // RL19
                            done <= 1'b1; // RL19
                        end else if (is_rw && func_ok) begin
                            if (f_func == `RMW_FUNC_TO_REG) begin
                                src_byte <= byte_operand_reg; // RL1
                                state    <= ST_WRITE;
                            end else begin
                                chip_reg_addr <= f_addr; // RL2 RL3
                                chip_reg_rd   <= 1'b1;
                                state         <= ST_READ;
                            end
                        end else begin
                            busy    <= 1'b0;
                            illegal <= 1'b1;
                            done    <= 1'b1;
                        end
                    end
                end
                ST_READ: begin
                    // register data valid in the cycle the read strobe is up, sampled at its closing edge
                    src_byte <= chip_reg_rdata; // RL18
                    state    <= ST_WRITE;
                end
                ST_WRITE: begin
                    carry <= alu_carry; // RL7 RL21
                    if (f_func == `RMW_FUNC_TO_BOR) begin
                        byte_operand_reg <= alu_out; // RL2
                    end else begin
                        chip_reg_addr  <= f_addr;  // RL1 RL3 RL17
                        chip_reg_wdata <= alu_out; // RL1 RL3
                        chip_reg_wr    <= 1'b1;
                    end
                    busy  <= 1'b0;
                    done  <= 1'b1;
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave: instruction words, go strobe, status
    wire wr_fire = aw_held && w_held && !s_axi_bvalid;
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RMW_RESP_OKAY;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 5'h00;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
            instr_word0   <= 32'h00000000;
            instr_word1   <= 32'h00000000;
            go            <= 1'b0;
        end else begin
            go            <= 1'b0;
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `RMW_RESP_OKAY;
                // instruction words are frozen while an instruction runs
                case ({aw_addr[4:2], 2'b00})
                    `RMW_AXI_CTRL: begin
                        if (w_strb[0] && w_data[`RMW_CTRL_GO_BIT] && !busy) begin
                            go <= 1'b1;
                        end
                    end
                    `RMW_AXI_WORD0: begin
                        if (!busy) begin
                            instr_word0 <= merge(instr_word0, w_data, w_strb);
                        end
                    end
                    `RMW_AXI_WORD1: begin
                        if (!busy) begin
                            instr_word1 <= merge(instr_word1, w_data, w_strb);
                        end
                    end
                    `RMW_AXI_STATUS: ;
                    `RMW_AXI_BOR: ;
                    default: s_axi_bresp <= `RMW_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RMW_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `RMW_RESP_OKAY;
                case ({s_axi_araddr[4:2], 2'b00})
                    `RMW_AXI_CTRL:   s_axi_rdata <= 32'h00000000;
                    `RMW_AXI_WORD0:  s_axi_rdata <= instr_word0;
                    `RMW_AXI_WORD1:  s_axi_rdata <= instr_word1;
                    `RMW_AXI_STATUS: s_axi_rdata <= {28'h0000000, !busy, illegal, carry, busy};
                    `RMW_AXI_BOR:    s_axi_rdata <= {24'h000000, byte_operand_reg};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `RMW_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// [rmw_alu_asserts.sv]
// port-level checks on the register read/write datapath
`timescale 1ns/1ps
module rmw_alu_asserts (
    input logic       clock,
    input logic       resetn,
    input logic       s_axi_awready,
    input logic       s_axi_bvalid,
    input logic       s_axi_bready,
    input logic       s_axi_rvalid,
    input logic       s_axi_rready,
    input logic [6:0] chip_reg_addr,
    input logic       chip_reg_rd,
    input logic       chip_reg_wr,
    input logic [7:0] byte_operand_reg,
    input logic       carry,
    input logic       done
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////////////
    a_read_then_done: assert property (chip_reg_rd |-> ##2 done)
        else $error("read strobe not followed by done");
    a_read_single: assert property (chip_reg_rd |=> !chip_reg_rd [*2])
        else $error("read strobe repeated");
    a_addr_held: assert property (chip_reg_rd |=> ($stable(chip_reg_addr)) [*2])
        else $error("register address moved during instruction");
    a_write_with_done: assert property (chip_reg_wr |-> done)
        else $error("write strobe outside completion");
    a_carry_at_done: assert property (!$stable(carry) |-> done)
        else $error("carry changed outside completion");
    a_operand_at_done: assert property (!$stable(byte_operand_reg) |-> done && !chip_reg_wr)
        else $error("byte operand changed outside a read form");
    a_done_single: assert property (done |=> !done)
        else $error("done longer than one cycle");
    a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_rresp_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
    a_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready longer than one cycle");
endmodule
bind rmw_alu rmw_alu_asserts i_chk (.clock, .resetn, .s_axi_awready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .chip_reg_addr, .chip_reg_rd,
    .chip_reg_wr, .byte_operand_reg, .carry, .done);

// [rmw_chip_regs.sv]
// behavioural model of the chip byte registers behind the datapath
`timescale 1ns/1ps
module rmw_chip_regs (
    input  logic       clock,
    input  logic [6:0] chip_reg_addr,
    input  logic       chip_reg_rd,
    input  logic       chip_reg_wr,
    input  logic [7:0] chip_reg_wdata,
    output logic [7:0] chip_reg_rdata
);
    logic [7:0] mem [0:127];
    logic [7:0] junk = 8'h00;
    // data stands only while the strobe is up; toggling junk exposes a late sample
    assign chip_reg_rdata = chip_reg_rd ? mem[chip_reg_addr] : junk;
    always @(posedge clock) begin
        junk <= ~junk;
        if (chip_reg_wr)
            mem[chip_reg_addr] <= chip_reg_wdata;
    end
endmodule

// [tb_top.sv]
// self-checking bench for the register read/write datapath
`timescale 1ns/1ps
`include "rmw_map.vh"
module tb_top;
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire  [6:0]  chip_reg_addr;
    wire  [7:0]  chip_reg_rdata, chip_reg_wdata, byte_operand_reg;
    wire         chip_reg_rd, chip_reg_wr, carry, done;
    int          num_errors = 0, compares = 0, n_done = 0, n_wr = 0, w;
    logic [7:0]  exp_bor, exp_mem, src, opnd, res, imm;
    logic [6:0]  a;
    logic [2:0]  fn, op;
    logic        exp_c, ub;
    logic [1:0]  resp;
    logic [31:0] rd;

    rmw_alu i_dut (.clock, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chip_reg_addr, .chip_reg_rd,
        .chip_reg_rdata, .chip_reg_wr, .chip_reg_wdata, .byte_operand_reg, .carry, .done);
    rmw_chip_regs i_regs (.clock, .chip_reg_addr, .chip_reg_rd, .chip_reg_wr,
        .chip_reg_wdata, .chip_reg_rdata);

    always #2.5 clock = ~clock;
    always @(posedge clock) begin
        if (done)
            n_done <= n_done + 1;
        if (chip_reg_wr)
            n_wr <= n_wr + 1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic axi_wr(input logic [4:0] ad, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge clock);
            if (s_axi_awready)
                ta = 1'b1;
            if (s_axi_wready)
                tw = 1'b1;
            s_axi_awvalid <= !ta;
            s_axi_wvalid <= !tw;
        end
        do @(posedge clock); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clock);
    endtask

    task automatic axi_rd(input logic [4:0] ad, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clock); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clock); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clock);
    endtask

    task automatic run(input logic [31:0] w0);
        int c;
        c = n_done;
        w = n_wr;
        axi_wr(`RMW_AXI_WORD0, w0, resp);
        axi_wr(`RMW_AXI_CTRL, 32'h1, resp);
        check(resp, `RMW_RESP_OKAY, "go response");
        repeat (20) if (n_done == c) @(posedge clock);
        @(negedge clock);
        check(n_done - c, 1, "done count");
        @(posedge clock);
    endtask

    task automatic print_verdict;
        if (num_errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        num_errors++;
        print_verdict();
    end

    initial begin
        exp_c = 1'b0;
        exp_bor = 8'h00;
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        axi_wr(`RMW_AXI_WORD1, 32'h0, resp);
        for (int i = 0; i < 48; i++) begin
            fn = 3'(5 + i / 16);
            op = i[3:1];
            ub = i[0] && op != `RMW_OP_SHL && op != `RMW_OP_SHR;
            a = 7'h7f - i[6:0];
            imm = 8'h3c + 8'(i * 41);
            i_regs.mem[a] = 8'h96 ^ 8'(i * 23);
            exp_mem = i_regs.mem[a];
            src = (fn == `RMW_FUNC_TO_REG) ? exp_bor : exp_mem;
            opnd = ub ? exp_bor : imm;
            case (op)
                3'h0: res = (fn != `RMW_FUNC_TO_REG && !ub) ? imm : src;
                3'h1: {exp_c, res} = {src, exp_c};
                3'h2: res = src | opnd;
                3'h3: res = src ^ opnd;
                3'h4: res = src & opnd;
                3'h5: {res, exp_c} = {exp_c, src};
                3'h6: {exp_c, res} = src + opnd;
                default: {exp_c, res} = src + opnd + exp_c;
            endcase
            run({2'b01, fn, op, ub, a, imm, 8'h00});
            if (fn == `RMW_FUNC_TO_BOR)
                exp_bor = res;
            else
                exp_mem = res;
            check(i_regs.mem[a], exp_mem, "chip register");
            check(byte_operand_reg, exp_bor, "byte operand");
            check(carry, exp_c, "carry");
            check(n_wr - w, fn != `RMW_FUNC_TO_BOR, "write strobes");
        end
        run(32'h8000_0000);
        check(n_wr - w, 0, "nop writes");
        check({byte_operand_reg, carry}, {exp_bor, exp_c}, "nop state");
        axi_rd(`RMW_AXI_BOR, rd, resp);
        check(rd[7:0], exp_bor, "operand readback");
        axi_rd(`RMW_AXI_STATUS, rd, resp);
        check(rd[`RMW_ST_CARRY_BIT], exp_c, "status carry");
        run(32'h0000_0000);
        axi_rd(`RMW_AXI_STATUS, rd, resp);
        check(rd[`RMW_ST_ILLEGAL_BIT], 1, "illegal flag");
        axi_rd(5'h14, rd, resp);
        check(resp, `RMW_RESP_SLVERR, "unmapped read");
        print_verdict();
    end
endmodule
